// ==== hdl/smsp_regs.svh ====
`ifndef SMSP_REGS_SVH
`define SMSP_REGS_SVH
// ----------------------------------------
// register indices on the register port
// ----------------------------------------
`define SMSP_IDX_MCU 2'h0
`define SMSP_IDX_CTRL 2'h1
`define SMSP_IDX_STAT 2'h2
`define SMSP_IDX_DATA 2'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define SMSP_MCU_ROUTE 7
`define SMSP_CTRL_IRQ_EN 7
`define SMSP_CTRL_PORT_EN 6
`define SMSP_CTRL_ORDER 5
`define SMSP_CTRL_MASTER 4
`define SMSP_CTRL_IDLE 3
`define SMSP_CTRL_EDGE 2
`define SMSP_CTRL_RATE_HI 1
`define SMSP_CTRL_RATE_LO 0
`define SMSP_STAT_DONE 7
`define SMSP_STAT_WRITE_COLLISION_FLAG 6
`define SMSP_STAT_DBL 0
// pin direction bits, one per serial signal
`define SMSP_DIR_MOSI 0
`define SMSP_DIR_MISO 1
`define SMSP_DIR_SCK 2
`define SMSP_DIR_SS 3
// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define SMSP_MCU_RESET 8'h00
`define SMSP_MCU_WMASK 8'h93
`define SMSP_CTRL_RESET 8'h00
`define SMSP_STAT_RESET 8'h00
`define SMSP_DATA_RESET 8'h00
// ----------------------------------------
// timing: half sck periods in clock cycles, clock and peer sck periods in ns
// ----------------------------------------
`define SMSP_HALF_DIV4 7'h02
`define SMSP_HALF_DIV16 7'h08
`define SMSP_HALF_DIV64 7'h20
`define SMSP_HALF_DIV128 7'h40
`define SMSP_HALF_DIV2 7'h01
`define SMSP_HALF_DIV8 7'h04
`define SMSP_HALF_DIV32 7'h10
`define SMSP_CLK_NS 100
// slack for both synchroniser chains plus the pin register on each side
`define SMSP_PEER_SCK_NS 3200
`define SMSP_PEER_HALF (`SMSP_PEER_SCK_NS / (2 * `SMSP_CLK_NS))
`endif

// ==== hdl/smsp_pkg.sv ====
package smsp_pkg;
	// device shift states
	typedef enum logic [2:0] {
		DEV_IDLE = 3'b001,
		DEV_MSHIFT = 3'b010,
		DEV_SSHIFT = 3'b100
	} smsp_dev_state_type;
	// peer transfer states
	typedef enum logic [3:0] {
		PEER_IDLE = 4'b0001,
		PEER_SEL = 4'b0010,
		PEER_SHIFT = 4'b0100,
		PEER_DESEL = 4'b1000
	} smsp_peer_state_type;
	typedef logic [1:0] smsp_idx_type;
	typedef logic [7:0] smsp_byte_type;
endpackage : smsp_pkg

// ==== hdl/smsp_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// index 0 is the primary pin set, index 1 the alternate set
interface smsp_link_if;
	logic [1:0] dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
	logic [1:0] dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe;
	logic [1:0] peer_sck_o, peer_sck_oe, peer_mosi_o, peer_mosi_oe;
	logic [1:0] peer_miso_o, peer_miso_oe, peer_ss_o, peer_ss_oe;
	logic [1:0] sck_ln, mosi_ln, miso_ln, ss_ln;
	// ----------------------------------------
	// wire levels, undriven lines pulled high
	// ----------------------------------------
	function automatic logic [1:0] res(input logic [1:0] d_o,
		input logic [1:0] d_oe, input logic [1:0] p_o,
		input logic [1:0] p_oe);
		res = (d_oe & d_o) | (~d_oe & p_oe & p_o) | (~d_oe & ~p_oe);
	endfunction : res
	assign sck_ln = res(dev_sck_o, dev_sck_oe, peer_sck_o, peer_sck_oe);
	assign mosi_ln = res(dev_mosi_o, dev_mosi_oe, peer_mosi_o,
		peer_mosi_oe);
	assign miso_ln = res(dev_miso_o, dev_miso_oe, peer_miso_o,
		peer_miso_oe);
	assign ss_ln = res(dev_ss_o, dev_ss_oe, peer_ss_o, peer_ss_oe);
	modport dev_mp(output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
		dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe,
		input sck_ln, mosi_ln, miso_ln, ss_ln);
	modport peer_mp(output peer_sck_o, peer_sck_oe, peer_mosi_o,
		peer_mosi_oe, peer_miso_o, peer_miso_oe, peer_ss_o, peer_ss_oe,
		input sck_ln, mosi_ln, miso_ln, ss_ln);
endinterface : smsp_link_if
`default_nettype wire

// ==== hdl/smsp_pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module smsp_pin_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk_in, // io clock
	input wire logic reset_n_in, // async reset, active low
	input wire logic en_in, // clock enable
	input wire logic [WIDTH-1:0] pin_in, // raw pin levels
	output logic [WIDTH-1:0] level_out // filtered levels
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
	// ----------------------------------------
	// three stages, change taken once 2 and 3 agree
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			lvl_q <= '1;
		end else if (en_in) begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
		end
	end
	assign level_out = lvl_q;
endmodule : smsp_pin_sync
`default_nettype wire

// ==== hdl/smsp_device.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "smsp_regs.svh"
module smsp_device
	import smsp_pkg::*;
(
	input wire logic clk_in, // io clock
	input wire logic reset_n_in, // async reset, active low
	input wire logic en_in, // clock enable, freezes state when low
	input wire logic [1:0] reg_idx_in, // register index
	input wire logic reg_wr_in, // register write strobe
	input wire logic reg_rd_in, // register read strobe
	input wire logic [7:0] reg_wdata_in, // write data
	output logic [7:0] reg_rdata_out, // read data, one cycle later
	input wire logic irq_ack_in, // interrupt vector executed
	input wire logic global_irq_en_in, // global interrupt enable
	input wire logic pkg_24pin_in, // small package strap
	input wire logic prog_mode_in, // in-system programming active
	input wire logic [3:0] pin_dir_in, // user pin directions, 1 = out
	input wire logic ss_level_in, // select level when used as gpio
	output logic irq_out, // serial interrupt request
	smsp_link_if.dev_mp link // serial pins, both sets
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	smsp_dev_state_type state_q;
	logic [7:0] mcu_q, ctrl_q, sh_q, rxbuf_q, rdata_q;
	logic dbl_q, done_q, write_collision_flag_q, done_arm_q, write_collision_flag_arm_q, irq_q;
	logic sck_q, out_q, sck_prev_q;
	logic [3:0] cnt_q;
	logic [6:0] div_q, half;
	logic [3:0] raw_in, syn;
	logic sel_alt, enabled, master, ss_s, sck_s, din, fallback, slave_act;
	logic dwr, dacc, busy, edge_m, edge_s, edge_any, lead, sample, setup;
	logic last, order, clock_capture_edge, head;
	logic [7:0] shifted;

	// ----------------------------------------
	// pin routing and input synchronisers
	// ----------------------------------------
	// programming port forces the alternate set
	assign sel_alt = prog_mode_in |
		(mcu_q[`SMSP_MCU_ROUTE] ^ pkg_24pin_in);
	assign raw_in = sel_alt ?
		{link.ss_ln[1], link.sck_ln[1], link.miso_ln[1], link.mosi_ln[1]} :
		{link.ss_ln[0], link.sck_ln[0], link.miso_ln[0], link.mosi_ln[0]};
	smsp_pin_sync #(.WIDTH(4)) u_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.en_in(en_in),
		.pin_in(raw_in),
		.level_out(syn)
	);

	// ----------------------------------------
	// decode of mode, edges and accesses
	// ----------------------------------------
	assign enabled = ctrl_q[`SMSP_CTRL_PORT_EN];
	assign master = ctrl_q[`SMSP_CTRL_MASTER];
	assign order = ctrl_q[`SMSP_CTRL_ORDER];
	assign clock_capture_edge = ctrl_q[`SMSP_CTRL_EDGE];
	assign ss_s = syn[`SMSP_DIR_SS];
	assign sck_s = syn[`SMSP_DIR_SCK];
	assign din = master ? syn[`SMSP_DIR_MISO] : syn[`SMSP_DIR_MOSI];
	assign fallback = enabled & master & ~pin_dir_in[`SMSP_DIR_SS] &
		~ss_s;
	assign slave_act = enabled & ~master & ~ss_s;
	assign dwr = reg_wr_in & (reg_idx_in == `SMSP_IDX_DATA);
	assign dacc = (reg_wr_in | reg_rd_in) & (reg_idx_in == `SMSP_IDX_DATA);
	assign busy = (state_q == DEV_MSHIFT) |
		((state_q == DEV_SSHIFT) & (cnt_q != 4'h0));
	// divider half period from rate and double bits
	always_comb begin
		case ({dbl_q, ctrl_q[`SMSP_CTRL_RATE_HI:`SMSP_CTRL_RATE_LO]})
		3'h0: half = `SMSP_HALF_DIV4;
		3'h1: half = `SMSP_HALF_DIV16;
		3'h2: half = `SMSP_HALF_DIV64;
		3'h3: half = `SMSP_HALF_DIV128;
		3'h4: half = `SMSP_HALF_DIV2;
		3'h5: half = `SMSP_HALF_DIV8;
		3'h6: half = `SMSP_HALF_DIV32;
		default: half = `SMSP_HALF_DIV64;
		endcase
	end
	assign edge_m = (state_q == DEV_MSHIFT) & (div_q == half - 7'h01);
	// slave relies on external clock no faster than io/4
	assign edge_s = (state_q == DEV_SSHIFT) & slave_act &
		(sck_s != sck_prev_q);
	assign edge_any = edge_m | edge_s;
	assign lead = (state_q == DEV_MSHIFT) ? ~cnt_q[0] :
		(sck_s != ctrl_q[`SMSP_CTRL_IDLE]);
	assign sample = edge_any & (lead ^ clock_capture_edge);
	assign setup = edge_any & ~(lead ^ clock_capture_edge);
	assign last = edge_any & (cnt_q == 4'hf);
	assign head = order ? sh_q[0] : sh_q[7];
	assign shifted = order ? {din, sh_q[7:1]} : {sh_q[6:0], din};

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= DEV_IDLE;
			cnt_q <= 4'h0;
			div_q <= 7'h00;
		end else if (en_in) begin
			case (state_q)
			DEV_IDLE: begin
				cnt_q <= 4'h0;
				div_q <= 7'h00;
				if (enabled & master & dwr & ~fallback) begin
					state_q <= DEV_MSHIFT;
				end else if (slave_act) begin
					state_q <= DEV_SSHIFT;
				end
			end
			DEV_MSHIFT: begin
				if (~enabled | ~master | fallback) begin
					state_q <= DEV_IDLE;
				end else if (edge_m) begin
					div_q <= 7'h00;
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'hf) begin
						state_q <= DEV_IDLE;
					end
				end else begin
					div_q <= div_q + 7'h01;
				end
			end
			DEV_SSHIFT: begin
				if (~slave_act) begin
					state_q <= DEV_IDLE;
					cnt_q <= 4'h0;
				end else if (edge_s) begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
			default: state_q <= DEV_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// shifter, receive buffer, serial output bit
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sh_q <= `SMSP_DATA_RESET;
			rxbuf_q <= `SMSP_DATA_RESET;
			out_q <= 1'b0;
			sck_prev_q <= 1'b0;
		end else if (en_in) begin
			sck_prev_q <= sck_s;
			if (dwr & ~busy) begin
				sh_q <= reg_wdata_in;
			end else if (sample) begin
				sh_q <= shifted;
			end
			// a finished byte overwrites any unread one
			if (last) begin
				rxbuf_q <= sample ? shifted : sh_q;
			end
			if (dwr & ~busy & ~clock_capture_edge) begin
				out_q <= order ? reg_wdata_in[0] : reg_wdata_in[7];
			end else if (setup) begin
				out_q <= head;
			end else if (~busy & ~clock_capture_edge) begin
				out_q <= head;
			end
		end
	end

	// master clock toggles on each half period, idles at polarity
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sck_q <= 1'b0;
		end else if (en_in) begin
			if (state_q != DEV_MSHIFT) begin
				sck_q <= ctrl_q[`SMSP_CTRL_IDLE];
			end else if (edge_m) begin
				sck_q <= ~sck_q;
			end
		end
	end

	// ----------------------------------------
	// registers and flags
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mcu_q <= `SMSP_MCU_RESET;
			ctrl_q <= `SMSP_CTRL_RESET;
			dbl_q <= 1'b0;
		end else if (en_in) begin
			if (reg_wr_in & (reg_idx_in == `SMSP_IDX_MCU)) begin
				mcu_q <= reg_wdata_in & `SMSP_MCU_WMASK;
			end
			if (reg_wr_in & (reg_idx_in == `SMSP_IDX_STAT)) begin
				dbl_q <= reg_wdata_in[`SMSP_STAT_DBL];
			end
			if (reg_wr_in & (reg_idx_in == `SMSP_IDX_CTRL)) begin
				ctrl_q <= reg_wdata_in;
			end
			if (fallback) begin
				ctrl_q[`SMSP_CTRL_MASTER] <= 1'b0;
			end
		end
	end

	// set wins over clear on both flags
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			done_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			done_arm_q <= 1'b0;
			write_collision_flag_arm_q <= 1'b0;
		end else if (en_in) begin
			done_q <= last | fallback | (done_q & ~(irq_ack_in |
				(dacc & (done_arm_q | write_collision_flag_arm_q))));
			write_collision_flag_q <= (dwr & busy) | (write_collision_flag_q & ~(dacc & write_collision_flag_arm_q));
			if (reg_rd_in & (reg_idx_in == `SMSP_IDX_STAT)) begin
				done_arm_q <= done_q;
				write_collision_flag_arm_q <= write_collision_flag_q;
			end else if (dacc) begin
				done_arm_q <= 1'b0;
				write_collision_flag_arm_q <= 1'b0;
			end
		end
	end

	// read data and interrupt request
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
		end else if (en_in) begin
			irq_q <= ctrl_q[`SMSP_CTRL_IRQ_EN] & done_q &
				global_irq_en_in;
			if (reg_rd_in) begin
				case (reg_idx_in)
				`SMSP_IDX_MCU: rdata_q <= mcu_q;
				`SMSP_IDX_CTRL: rdata_q <= ctrl_q;
				`SMSP_IDX_STAT: rdata_q <= {done_q, write_collision_flag_q, 5'h00,
					dbl_q};
				default: rdata_q <= rxbuf_q;
				endcase
			end
		end
	end

	// ----------------------------------------
	// pin drivers, only the selected set drives
	// ----------------------------------------
	for (genvar s = 0; s < 2; s++) begin : g_set
		logic act;
		assign act = (sel_alt == s[0]);
		always_ff @(posedge clk_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				link.dev_sck_o[s] <= 1'b0;
				link.dev_sck_oe[s] <= 1'b0;
				link.dev_mosi_o[s] <= 1'b0;
				link.dev_mosi_oe[s] <= 1'b0;
				link.dev_miso_o[s] <= 1'b0;
				link.dev_miso_oe[s] <= 1'b0;
				link.dev_ss_o[s] <= 1'b1;
				link.dev_ss_oe[s] <= 1'b0;
			end else if (en_in) begin
				link.dev_sck_o[s] <= sck_q;
				link.dev_mosi_o[s] <= out_q;
				link.dev_miso_o[s] <= out_q;
				link.dev_ss_o[s] <= ss_level_in;
				link.dev_sck_oe[s] <= act & master & pin_dir_in[`SMSP_DIR_SCK];
				link.dev_mosi_oe[s] <= act & enabled & master &
					pin_dir_in[`SMSP_DIR_MOSI];
				link.dev_miso_oe[s] <= act & slave_act &
					pin_dir_in[`SMSP_DIR_MISO];
				link.dev_ss_oe[s] <= act & master &
					pin_dir_in[`SMSP_DIR_SS];
			end
		end
	end

	assign reg_rdata_out = rdata_q;
	assign irq_out = irq_q;
endmodule : smsp_device
`default_nettype wire

// ==== hdl/smsp_peer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "smsp_regs.svh"
module smsp_peer
	import smsp_pkg::*;
(
	input wire logic clk_in, // io clock
	input wire logic reset_n_in, // async reset, active low
	input wire logic en_in, // clock enable
	input wire logic start_in, // start one byte, pulse
	input wire logic [7:0] tx_in, // byte to send
	input wire logic [1:0] mode_in, // {idle level, capture edge}
	input wire logic lsb_first_in, // bit order
	input wire logic alt_set_in, // use alternate pin set
	input wire logic ss_drive_in, // drive select line
	output logic [7:0] rx_out, // byte received
	output logic done_out, // byte finished, pulse
	output logic busy_out, // transfer running
	smsp_link_if.peer_mp link // serial pins, both sets
);
	smsp_peer_state_type state_q;
	logic [7:0] sh_q, rx_q;
	logic [6:0] div_q;
	logic [3:0] cnt_q;
	logic sck_q, out_q, ss_q, done_q, alt_q, miso_s, tick, lead, sample;
	logic head;
	logic [7:0] shifted;

	smsp_pin_sync #(.WIDTH(1)) u_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.en_in(en_in),
		.pin_in(alt_q ? link.miso_ln[1] : link.miso_ln[0]),
		.level_out(miso_s)
	);
	// half period keeps sck at or below io/4 for the device
	assign tick = (div_q == 7'(`SMSP_PEER_HALF - 1));
	assign lead = ~cnt_q[0];
	assign sample = (state_q == PEER_SHIFT) & tick & (lead ^ mode_in[0]);
	assign head = lsb_first_in ? sh_q[0] : sh_q[7];
	assign shifted = lsb_first_in ? {miso_s, sh_q[7:1]} :
		{sh_q[6:0], miso_s};

	// ----------------------------------------
	// master sequence: select, 16 edges, deselect
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= PEER_IDLE;
			div_q <= 7'h00;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			rx_q <= 8'h00;
			sck_q <= 1'b0;
			out_q <= 1'b0;
			ss_q <= 1'b1;
			done_q <= 1'b0;
			alt_q <= 1'b0;
		end else if (en_in) begin
			done_q <= 1'b0;
			div_q <= tick ? 7'h00 : div_q + 7'h01;
			case (state_q)
			PEER_IDLE: begin
				sck_q <= mode_in[1];
				ss_q <= 1'b1;
				div_q <= 7'h00;
				cnt_q <= 4'h0;
				if (start_in) begin
					state_q <= PEER_SEL;
					sh_q <= tx_in;
					alt_q <= alt_set_in;
					ss_q <= 1'b0;
					out_q <= lsb_first_in ? tx_in[0] : tx_in[7];
				end
			end
			PEER_SEL: if (tick) state_q <= PEER_SHIFT;
			PEER_SHIFT: if (tick) begin
				sck_q <= ~sck_q;
				cnt_q <= cnt_q + 4'h1;
				if (sample) begin
					sh_q <= shifted;
				end else begin
					out_q <= head;
				end
				if (cnt_q == 4'hf) begin
					state_q <= PEER_DESEL;
					rx_q <= sample ? shifted : sh_q;
				end
			end
			PEER_DESEL: if (tick) begin
				state_q <= PEER_IDLE;
				ss_q <= 1'b1;
				done_q <= 1'b1;
			end
			default: state_q <= PEER_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// pin drivers on the chosen set
	// ----------------------------------------
	for (genvar s = 0; s < 2; s++) begin : g_set
		always_ff @(posedge clk_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				link.peer_sck_o[s] <= 1'b0;
				link.peer_sck_oe[s] <= 1'b0;
				link.peer_mosi_o[s] <= 1'b0;
				link.peer_mosi_oe[s] <= 1'b0;
				link.peer_ss_o[s] <= 1'b1;
				link.peer_ss_oe[s] <= 1'b0;
				link.peer_miso_o[s] <= 1'b0;
				link.peer_miso_oe[s] <= 1'b0;
			end else if (en_in) begin
				link.peer_sck_o[s] <= sck_q;
				link.peer_mosi_o[s] <= out_q;
				link.peer_ss_o[s] <= ss_q;
				link.peer_sck_oe[s] <= (alt_q == s[0]) &
					(state_q != PEER_IDLE);
				link.peer_mosi_oe[s] <= (alt_q == s[0]) &
					(state_q != PEER_IDLE);
				link.peer_ss_oe[s] <= (alt_set_in == s[0]) & ss_drive_in;
			end
		end
	end

	assign rx_out = rx_q;
	assign done_out = done_q;
	assign busy_out = (state_q != PEER_IDLE);
endmodule : smsp_peer
`default_nettype wire

// ==== tb/smsp_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// link checker, watches the shared pins
// ----------------------------------------
module smsp_chk (
	input wire logic clk_in, // io clock
	input wire logic reset_n_in, // async reset, active low
	input wire logic [1:0] dev_sck_oe, // device clock enables
	input wire logic [1:0] dev_mosi_oe, // device mosi enables
	input wire logic [1:0] dev_miso_oe, // device miso enables
	input wire logic [1:0] dev_ss_oe, // device select enables
	input wire logic [1:0] peer_sck_o, // peer clock levels
	input wire logic [1:0] peer_ss_o, // peer select levels
	input wire logic [1:0] ss_ln // resolved select levels
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// pin ownership by set and role
	AST_ONE_SET: assert property (
		$onehot0(dev_sck_oe | dev_mosi_oe | dev_miso_oe | dev_ss_oe))
		else $error("device pins enabled on both sets");
	AST_MISO_MOSI: assert property (
		!(dev_miso_oe[0] && dev_mosi_oe[0]))
		else $error("miso and mosi driven together");
	AST_MISO_SCK: assert property (
		!(dev_miso_oe[0] && dev_sck_oe[0]))
		else $error("miso driven while driving sck");
	// select gating of the slave output
	AST_MISO_ON: assert property (
		$rose(dev_miso_oe[0]) |-> !ss_ln[0])
		else $error("miso enabled with select high");
	AST_MISO_OFF: assert property (
		$rose(ss_ln[0]) && !dev_ss_oe[0] |-> ##[1:6] !dev_miso_oe[0])
		else $error("miso still driven after deselect");
	// master reaction to a low select
	AST_FALLBACK: assert property (
		$fell(ss_ln[0]) && !dev_ss_oe[0] && dev_sck_oe[0]
		|-> ##[1:6] !dev_sck_oe[0] && !dev_mosi_oe[0])
		else $error("master kept pins after select low");
	AST_SS_GPIO: assert property (
		$fell(ss_ln[0]) && dev_ss_oe[0] && dev_sck_oe[0]
		|=> dev_sck_oe[0] [*6])
		else $error("select output disturbed master");
	// peer clock stays within the slave sampling limit
	AST_PEER_HALF: assert property (
		$changed(peer_sck_o[0]) && !peer_ss_o[0]
		|=> $stable(peer_sck_o[0]) [*7])
		else $error("peer sck half period too short");
endmodule : smsp_chk
`default_nettype wire

// ==== tb/spi_master_slave_port_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_master_slave_port_tb
	import smsp_pkg::*;
;
	typedef struct {
		logic [1:0] md;
		logic ls, m7, pk, pg, ie;
		smsp_byte_type pt, dt;
	} smsp_row_type;
	// peer to slave rows: mode, order, route, irq enable, bytes
	smsp_row_type rows [5] = '{
		'{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'ha5, 8'h3c},
		'{2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h81, 8'h7e},
		'{2'h2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'h01, 8'h80},
		'{2'h3, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'hc3, 8'h5a},
		'{2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'hf0, 8'h0f}};
	// master half periods in cycles for {double, rate}
	int hv [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
	logic clk_in = 1'b0, reset_n_in = 1'b0, wr = 1'b0, rd = 1'b0;
	logic ack = 1'b0, gie = 1'b0, pkg = 1'b0, prog = 1'b0, ssl = 1'b1;
	logic start = 1'b0, lsb = 1'b0, alt = 1'b0, ssdrv = 1'b1, irq, pdone;
	smsp_idx_type idx = 2'h0;
	smsp_byte_type wd = 8'h00, ptx = 8'h00, rdat, prx;
	logic [3:0] dir = 4'h0;
	logic [1:0] mode = 2'h0;
	int n_errors = 0, checks_done = 0;
	// ----------------------------------------
	// clock and the two ends
	// ----------------------------------------
	always #50 clk_in = ~clk_in;
	smsp_link_if link_i ();
	smsp_device smsp_device_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.en_in(1'b1), .reg_idx_in(idx), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wd), .reg_rdata_out(rdat), .irq_ack_in(ack),
		.global_irq_en_in(gie), .pkg_24pin_in(pkg), .prog_mode_in(prog),
		.pin_dir_in(dir), .ss_level_in(ssl), .irq_out(irq), .link(link_i));
	smsp_peer smsp_peer_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.en_in(1'b1), .start_in(start), .tx_in(ptx), .mode_in(mode),
		.lsb_first_in(lsb), .alt_set_in(alt), .ss_drive_in(ssdrv),
		.rx_out(prx), .done_out(pdone), .busy_out(), .link(link_i));
	smsp_chk smsp_chk_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.dev_sck_oe(link_i.dev_sck_oe), .dev_mosi_oe(link_i.dev_mosi_oe),
		.dev_miso_oe(link_i.dev_miso_oe), .dev_ss_oe(link_i.dev_ss_oe),
		.peer_sck_o(link_i.peer_sck_o), .peer_ss_o(link_i.peer_ss_o),
		.ss_ln(link_i.ss_ln));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wreg(input smsp_idx_type i, input smsp_byte_type d);
		@(posedge clk_in);
		idx <= i;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input string nm, input smsp_idx_type i,
		input smsp_byte_type e);
		@(posedge clk_in);
		idx <= i;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		chk(nm, rdat, e);
	endtask : rchk
	task automatic pstart(input smsp_byte_type b);
		@(posedge clk_in);
		ptx <= b;
		start <= 1'b1;
		@(posedge clk_in);
		start <= 1'b0;
	endtask : pstart
	// waits for the peer frame, then lets the slave flags settle
	task automatic pwait();
		int i;
		for (i = 0; i < 400 && pdone !== 1'b1; i++) begin
			@(posedge clk_in);
			#1;
		end
		repeat (6) @(posedge clk_in);
	endtask : pwait
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// watchdog against a hung handshake
	initial begin
		#3000000;
		n_errors++;
		summarize();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		smsp_byte_type got, tx;
		int k, e, n, t0, t1;
		logic c, p;
		repeat (5) @(posedge clk_in);
		reset_n_in <= 1'b1;
		rchk("mcu reset", 2'h0, 8'h00);
		rchk("ctrl reset", 2'h1, 8'h00);
		rchk("stat reset", 2'h2, 8'h00);
		rchk("data reset", 2'h3, 8'h00);
		wreg(2'h0, 8'hff);
		rchk("mcu mask", 2'h0, 8'h93);
		wreg(2'h2, 8'hff);
		rchk("stat mask", 2'h2, 8'h01);
		wreg(2'h0, 8'h00);
		wreg(2'h2, 8'h00);
		$display("test registers done");
		// peer master against device slave, every mode and route
		gie <= 1'b1;
		dir <= 4'h2;
		foreach (rows[r]) begin
			mode <= rows[r].md;
			lsb <= rows[r].ls;
			pkg <= rows[r].pk;
			prog <= rows[r].pg;
			alt <= rows[r].pg | (rows[r].m7 ^ rows[r].pk);
			wreg(2'h0, {rows[r].m7, 7'h00});
			wreg(2'h1, {rows[r].ie, 1'b1, rows[r].ls, 1'b0, rows[r].md, 2'h0});
			wreg(2'h3, rows[r].dt);
			pstart(rows[r].pt);
			pwait();
			chk("peer rx", prx, rows[r].dt);
			chk("irq", {7'h00, irq}, {7'h00, rows[r].ie});
			rchk("stat done", 2'h2, 8'h80);
			rchk("slave rx", 2'h3, rows[r].pt);
			rchk("stat clear", 2'h2, 8'h00);
		end
		$display("test rows done");
		// device master at every rate, collision in mid byte
		prog <= 1'b0;
		pkg <= 1'b0;
		wreg(2'h0, 8'h00);
		for (k = 0; k < 8; k++) begin
			tx = 8'h6a ^ {k[2:0], 5'h0d};
			ssl <= 1'b1;
			dir <= k[0] ? 4'hd : 4'h5;
			wreg(2'h2, {7'h00, k[2]});
			wreg(2'h1, {2'h1, k[2], 1'b1, k[1:0], k[1:0]});
			wreg(2'h3, tx);
			n = 0;
			c = 1'b0;
			t0 = 0;
			t1 = 0;
			got = 8'h00;
			#1;
			p = link_i.sck_ln[0];
			for (e = 0; e < 2400 && n < 16; e++) begin
				@(posedge clk_in);
				ssl <= 1'b0;
				wr <= (n == 6) && !c;
				idx <= 2'h3;
				wd <= 8'hee;
				c = c | (n == 6);
				#1;
				if (link_i.sck_ln[0] !== p) begin
					n++;
					p = link_i.sck_ln[0];
					t0 = (n == 1) ? e : t0;
					t1 = e;
					if (n[0] != k[0])
						got = k[2] ? {link_i.mosi_ln[0], got[7:1]} :
							{got[6:0], link_i.mosi_ln[0]};
				end
			end
			repeat (4) @(posedge clk_in);
			chk("edges", 8'(n), 8'h10);
			chk("span", 8'(t1 - t0 - 15 * hv[k]), 8'h00);
			chk("mosi", got, tx);
			chk("idle sck", {7'h00, link_i.sck_ln[0]}, {7'h00, k[1]});
			rchk("stat write_collision_flag", 2'h2, {2'h3, 5'h00, k[2]});
			rchk("master rx", 2'h3, 8'hff);
			rchk("stat clear", 2'h2, {7'h00, k[2]});
			// let the select line settle high before its direction flips
			ssl <= 1'b1;
			repeat (6) @(posedge clk_in);
		end
		$display("test master done");
		// select forced low while master with select as input
		mode <= 2'h0;
		lsb <= 1'b0;
		alt <= 1'b0;
		dir <= 4'h5;
		wreg(2'h2, 8'h00);
		wreg(2'h1, 8'h50);
		pstart(8'h3e);
		repeat (8) @(posedge clk_in);
		rchk("ctrl fallback", 2'h1, 8'h40);
		rchk("stat fallback", 2'h2, 8'h80);
		pwait();
		@(posedge clk_in);
		ack <= 1'b1;
		@(posedge clk_in);
		ack <= 1'b0;
		rchk("stat ack", 2'h2, 8'h00);
		rchk("fallback rx", 2'h3, 8'h3e);
		wreg(2'h1, 8'h50);
		rchk("ctrl restore", 2'h1, 8'h50);
		$display("test fallback done");
		// disabled port, then a byte cut short by select
		dir <= 4'h2;
		wreg(2'h1, 8'h00);
		pstart(8'h77);
		pwait();
		rchk("stat disabled", 2'h2, 8'h00);
		wreg(2'h1, 8'h40);
		pstart(8'h99);
		repeat (40) @(posedge clk_in);
		ssdrv <= 1'b0;
		pwait();
		ssdrv <= 1'b1;
		rchk("stat abort", 2'h2, 8'h00);
		pstart(8'h5c);
		pwait();
		rchk("rx after abort", 2'h3, 8'h5c);
		$display("test abort done");
		summarize();
	end
endmodule : spi_master_slave_port_tb
`default_nettype wire
